// File: verilog/dssd_decoder.sv
// data space select decoder top: core and test port to register selects
// Functional notes
// - peripheral locations decode as plain data addresses, no special cycle.
// - ascending 32-word slots, dual timer first, pwm second.
// - first gain amplifier selected in its 32-word slot.
// - second gain amplifier selected in its 32-word slot.
// - real-time counter is last slot; flash interface at separate base.
// - debug window is fixed top 256 data locations.
// - test port reaches debug registers only when flash security is off.
// - transfer upper word top, 32-bit word below, then transfer status.
// - core lock status below transfer status; debug control after gap.
// - step counter pair, debug status, peripheral base reg descending.
// - trace control, trace pointer, then two-word trace stages window.
// - breakpoint first addr, second addr, mask as two-word entries.
// - breakpoint control pair above addresses; counter below mask.
// - external signal control is lowest assigned; below it reserved.
// - word addresses; 4096-word peripheral region from its base.
`timescale 1ns/100ps
module dssd_decoder #(
    parameter int unsigned NSLOT = 27
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // core data access
    input  wire logic              core_req,
    input  wire logic              core_wr,
    input  wire logic [23:0]       core_addr,
    input  wire logic [1:0]        core_size,
    // test port access (arrives from the test clock, synchronised here)
    input  wire logic              tp_req,
    input  wire logic              tp_wr,
    input  wire logic [23:0]       tp_addr,
    input  wire logic              flash_secure,
    // selects
    output logic [NSLOT-1:0]       periph_sel,
    output logic                   dual_timer_sel,
    output logic                   irq_arbiter_sel,
    output logic                   gain_amp_first_sel,
    output logic                   gain_amp_second_sel,
    output logic                   flash_iface_sel,
    output logic [16:0]            dbg_sel,
    output logic                   sel_wr,
    output logic                   rd_zero,
    output logic                   access_err,
    output logic                   tp_denied,
    output logic                   tp_ack
);
    // =====================================================
    // test port synchronisers
    logic tp_req_m_r, tp_req_s_r, tp_req_d_r;
    logic sec_m_r, sec_s_r;
    logic tp_req_m_nxt, tp_req_s_nxt, tp_req_d_nxt;
    logic sec_m_nxt, sec_s_nxt;
    logic        tp_wr_m_r, tp_wr_s_r, tp_wr_m_nxt, tp_wr_s_nxt;
    logic [23:0] tp_addr_m_r, tp_addr_s_r, tp_addr_m_nxt, tp_addr_s_nxt;
    logic tp_start;
    always_comb begin
        tp_req_m_nxt = tp_req;
        tp_req_s_nxt = tp_req_m_r;
        tp_req_d_nxt = tp_req_s_r;
        sec_m_nxt    = flash_secure;
        sec_s_nxt    = sec_m_r;
        tp_wr_m_nxt   = tp_wr;
        tp_wr_s_nxt   = tp_wr_m_r;
        tp_addr_m_nxt = tp_addr;
        tp_addr_s_nxt = tp_addr_m_r;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tp_req_m_r <= 1'b0;
            tp_req_s_r <= 1'b0;
            tp_req_d_r <= 1'b0;
            sec_m_r    <= 1'b1;
            sec_s_r    <= 1'b1;
            tp_wr_m_r   <= 1'b0;
            tp_wr_s_r   <= 1'b0;
            tp_addr_m_r <= 24'h000000;
            tp_addr_s_r <= 24'h000000;
        end else begin
            tp_req_m_r <= tp_req_m_nxt;
            tp_req_s_r <= tp_req_s_nxt;
            tp_req_d_r <= tp_req_d_nxt;
            sec_m_r    <= sec_m_nxt;
            sec_s_r    <= sec_s_nxt;
            tp_wr_m_r   <= tp_wr_m_nxt;
            tp_wr_s_r   <= tp_wr_s_nxt;
            tp_addr_m_r <= tp_addr_m_nxt;
            tp_addr_s_r <= tp_addr_s_nxt;
        end
    end
    // port holds address and write; two stages settle them before use
    assign tp_start = tp_req_s_r && !tp_req_d_r;
    // =====================================================
    // source select: core has priority, test port waits for a cycle without core_req
    logic        use_tp;
    logic [23:0] acc_addr;
    logic        acc_wr;
    logic        acc_valid;
    logic        acc_word;
    logic        tp_pend_r, tp_pend_nxt;
    assign use_tp    = tp_pend_r && !core_req;
    assign acc_addr  = core_req ? core_addr : tp_addr_s_r;
    assign acc_wr    = core_req ? core_wr : tp_wr_s_r;
    assign acc_valid = core_req || use_tp;
    // test port only issues word cycles
    assign acc_word  = core_req ?
        (core_size == dssd_pkg::DSSD_SZ_WORD) : 1'b1;
    // =====================================================
    // decode
    logic              p_in;
    logic [NSLOT-1:0]  p_hit;
    logic              d_in;
    logic [16:0]       d_hit;
    dssd_periph_dec #(
        .NSLOT (NSLOT)
    ) u_periph (
        .addr      (acc_addr),
        .in_region (p_in),
        .slot_hit  (p_hit)
    );
    dssd_dbg_dec u_dbg (
        .addr      (acc_addr),
        .in_window (d_in),
        .dbg_hit   (d_hit)
    );
    // =====================================================
    // access state: one registered cycle per access
    dssd_pkg::dssd_state_t state_r, state_nxt;
    logic [NSLOT-1:0] psel_nxt;
    logic [16:0]      dsel_nxt;
    logic             wr_nxt, zero_nxt, err_nxt, deny_nxt, ack_nxt;
    logic             bad_size, tp_block;
    assign bad_size = p_in && !acc_word;
    assign tp_block = use_tp && d_in && sec_s_r;
    always_comb begin
        state_nxt   = dssd_pkg::DSSD_IDLE;
        psel_nxt    = '0;
        dsel_nxt    = '0;
        wr_nxt      = 1'b0;
        zero_nxt    = 1'b0;
        err_nxt     = 1'b0;
        deny_nxt    = 1'b0;
        ack_nxt     = use_tp;
        tp_pend_nxt = tp_pend_r || tp_start;
        if (use_tp) begin
            tp_pend_nxt = tp_start;
        end
        unique case (state_r)
            dssd_pkg::DSSD_IDLE,
            dssd_pkg::DSSD_HOLD,
            dssd_pkg::DSSD_ERR: begin
                if (acc_valid) begin
                    if (bad_size) begin
                        // select suppressed on size error
                        state_nxt = dssd_pkg::DSSD_ERR;
                        err_nxt   = 1'b1;
                        zero_nxt  = !acc_wr;
                    end else if (tp_block) begin
                        deny_nxt  = 1'b1;
                        zero_nxt  = !acc_wr;
                    end else begin
                        state_nxt = dssd_pkg::DSSD_HOLD;
                        // plain address match, no mode qualifier
                        psel_nxt  = p_hit;
                        dsel_nxt  = d_in ? d_hit : 17'h0;
                        wr_nxt    = acc_wr;
                        // unassigned location: no select, zero data
                        zero_nxt  = !acc_wr && (p_hit == '0) &&
                                    (dsel_nxt == 17'h0);
                    end
                end
            end
            default: state_nxt = dssd_pkg::DSSD_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r             <= dssd_pkg::DSSD_IDLE;
            tp_pend_r           <= 1'b0;
            periph_sel          <= '0;
            dual_timer_sel      <= 1'b0;
            irq_arbiter_sel     <= 1'b0;
            gain_amp_first_sel  <= 1'b0;
            gain_amp_second_sel <= 1'b0;
            flash_iface_sel     <= 1'b0;
            dbg_sel             <= '0;
            sel_wr              <= 1'b0;
            rd_zero             <= 1'b0;
            access_err          <= 1'b0;
            tp_denied           <= 1'b0;
            tp_ack              <= 1'b0;
        end else begin
            state_r             <= state_nxt;
            tp_pend_r           <= tp_pend_nxt;
            periph_sel          <= psel_nxt;
            dual_timer_sel      <= psel_nxt[dssd_pkg::SLOT_TIMER];
            irq_arbiter_sel     <= psel_nxt[dssd_pkg::SLOT_IRQ];
            gain_amp_first_sel  <= psel_nxt[dssd_pkg::SLOT_AMP0];
            gain_amp_second_sel <= psel_nxt[dssd_pkg::SLOT_AMP1];
            flash_iface_sel     <= psel_nxt[dssd_pkg::SLOT_FLASH];
            dbg_sel             <= dsel_nxt;
            sel_wr              <= wr_nxt;
            rd_zero             <= zero_nxt;
            access_err          <= err_nxt;
            tp_denied           <= deny_nxt;
            tp_ack              <= ack_nxt;
        end
    end
endmodule : dssd_decoder

// File: verilog/dssd_pkg.sv
// package: address map constants for the data space select decoder
package dssd_pkg;
    // =====================================================
    // widths
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned NUM_PERIPH  = 27;
    localparam int unsigned NUM_DBG     = 22;
    // =====================================================
    // peripheral region
    localparam logic [23:0] PERIPH_BASE = 24'h00f000;
    localparam logic [23:0] PERIPH_LAST = 24'h00ffff;
    localparam logic [23:0] SLOT_WORDS  = 24'h000020;
    localparam logic [23:0] TIMER_BASE  = 24'h00f000;
    localparam logic [23:0] PWM_BASE    = 24'h00f020;
    localparam logic [23:0] IRQ_BASE    = 24'h00f040;
    localparam logic [23:0] AMP0_BASE   = 24'h00f0a0;
    localparam logic [23:0] AMP1_BASE   = 24'h00f0c0;
    localparam logic [23:0] RTC_BASE    = 24'h00f320;
    localparam logic [23:0] FLASH_BASE  = 24'h00f400;
    // slot indices (slot = (addr - base) / 32, except flash at 26)
    localparam int unsigned SLOT_TIMER  = 0;
    localparam int unsigned SLOT_PWM    = 1;
    localparam int unsigned SLOT_IRQ    = 2;
    localparam int unsigned SLOT_AMP0   = 5;
    localparam int unsigned SLOT_AMP1   = 6;
    localparam int unsigned SLOT_RTC    = 25;
    localparam int unsigned SLOT_FLASH  = 26;
    // =====================================================
    // debug window
    localparam logic [23:0] DBG_BASE         = 24'hffff00;
    localparam logic [23:0] DBG_XFER_UPPER   = 24'hffffff;
    localparam logic [23:0] DBG_XFER_WORD    = 24'hfffffe;
    localparam logic [23:0] DBG_XFER_STATUS  = 24'hfffffd;
    localparam logic [23:0] CORE_LOCK_STATUS = 24'hfffffc;
    localparam logic [23:0] DBG_CONTROL      = 24'hffffa0;
    localparam logic [23:0] STEP_COUNTER     = 24'hffff9f;
    localparam logic [23:0] DBG_STATUS       = 24'hffff9d;
    localparam logic [23:0] PERIPH_BASE_REG  = 24'hffff9c;
    localparam logic [23:0] TRACE_CTRL       = 24'hffff9b;
    localparam logic [23:0] TRACE_POINTER    = 24'hffff9a;
    localparam logic [23:0] TRACE_STAGES     = 24'hffff99;
    localparam logic [23:0] BKPT_CTRL        = 24'hffff97;
    localparam logic [23:0] BKPT_ADDR_FIRST  = 24'hffff95;
    localparam logic [23:0] BKPT_ADDR_SECOND = 24'hffff93;
    localparam logic [23:0] BKPT_MASK        = 24'hffff91;
    localparam logic [23:0] BKPT_COUNTER     = 24'hffff8e;
    localparam logic [23:0] EXT_SIGNAL_CTRL  = 24'hffff8a;
    // =====================================================
    // transfer sizes
    typedef enum logic [1:0] {
        DSSD_SZ_BYTE = 2'h0,
        DSSD_SZ_WORD = 2'h1,
        DSSD_SZ_LONG = 2'h2
    } dssd_size_t;
    // one-hot debug window select index
    typedef enum logic [3:0] {
        DSSD_DXU = 4'h0, DSSD_DXW = 4'h1, DSSD_DXS = 4'h2,
        DSSD_CLS = 4'h3, DSSD_DCT = 4'h4, DSSD_STC = 4'h5,
        DSSD_DST = 4'h6, DSSD_PBR = 4'h7, DSSD_TCT = 4'h8,
        DSSD_TPT = 4'h9, DSSD_TST = 4'ha, DSSD_BCT = 4'hb,
        DSSD_BA1 = 4'hc, DSSD_BA2 = 4'hd, DSSD_BMK = 4'he,
        DSSD_BCN = 4'hf
    } dssd_dbg_t;
    localparam int unsigned DBG_EXT_IDX = 16;
    // =====================================================
    // fsm states
    typedef enum logic [2:0] {
        DSSD_IDLE = 3'b001,
        DSSD_HOLD = 3'b010,
        DSSD_ERR  = 3'b100
    } dssd_state_t;
endpackage : dssd_pkg

// File: verilog/dssd_periph_dec.sv
// peripheral region slot decoder
`timescale 1ns/100ps
module dssd_periph_dec #(
    parameter int unsigned NSLOT = 27
) (
    input  wire logic [23:0]      addr,
    output logic                  in_region,
    output logic [NSLOT-1:0]      slot_hit
);
    logic [23:0] off;
    logic [4:0]  idx;
    assign off = addr - dssd_pkg::PERIPH_BASE;
    // 4096-word region, all word addresses
    assign in_region = (addr >= dssd_pkg::PERIPH_BASE) &&
                       (addr <= dssd_pkg::PERIPH_LAST);
    assign idx = off[9:5];
    // =====================================================
    // ascending 32-word slots below the flash window
    genvar g;
    generate
        for (g = 0; g < NSLOT - 1; g++) begin : g_slot
            assign slot_hit[g] = in_region && (off[11:10] == 2'h0) &&
                                 (idx == 5'(g));
        end
    endgenerate
    // flash interface sits at its own base above the last slot
    assign slot_hit[NSLOT-1] = in_region &&
        (addr >= dssd_pkg::FLASH_BASE) &&
        (addr < dssd_pkg::FLASH_BASE + dssd_pkg::SLOT_WORDS);
endmodule : dssd_periph_dec

// File: verilog/dssd_dbg_dec.sv
// debug register window decoder
`timescale 1ns/100ps
module dssd_dbg_dec (
    input  wire logic [23:0] addr,
    output logic             in_window,
    output logic [16:0]      dbg_hit
);
    // =====================================================
    // fixed top 256 words, not moved by any base register
    assign in_window = (addr[23:8] == dssd_pkg::DBG_BASE[23:8]);
    always_comb begin
        dbg_hit = '0;
        unique case (addr)
            dssd_pkg::DBG_XFER_UPPER:   dbg_hit[dssd_pkg::DSSD_DXU] = 1'b1;
            dssd_pkg::DBG_XFER_WORD:    dbg_hit[dssd_pkg::DSSD_DXW] = 1'b1;
            dssd_pkg::DBG_XFER_STATUS:  dbg_hit[dssd_pkg::DSSD_DXS] = 1'b1;
            dssd_pkg::CORE_LOCK_STATUS: dbg_hit[dssd_pkg::DSSD_CLS] = 1'b1;
            dssd_pkg::DBG_CONTROL:      dbg_hit[dssd_pkg::DSSD_DCT] = 1'b1;
            dssd_pkg::STEP_COUNTER,
            dssd_pkg::STEP_COUNTER - 24'h1:
                dbg_hit[dssd_pkg::DSSD_STC] = 1'b1;
            dssd_pkg::DBG_STATUS:       dbg_hit[dssd_pkg::DSSD_DST] = 1'b1;
            dssd_pkg::PERIPH_BASE_REG:  dbg_hit[dssd_pkg::DSSD_PBR] = 1'b1;
            dssd_pkg::TRACE_CTRL:       dbg_hit[dssd_pkg::DSSD_TCT] = 1'b1;
            dssd_pkg::TRACE_POINTER:    dbg_hit[dssd_pkg::DSSD_TPT] = 1'b1;
            dssd_pkg::TRACE_STAGES,
            dssd_pkg::TRACE_STAGES - 24'h1:
                dbg_hit[dssd_pkg::DSSD_TST] = 1'b1;
            dssd_pkg::BKPT_CTRL,
            dssd_pkg::BKPT_CTRL - 24'h1:
                dbg_hit[dssd_pkg::DSSD_BCT] = 1'b1;
            dssd_pkg::BKPT_ADDR_FIRST,
            dssd_pkg::BKPT_ADDR_FIRST - 24'h1:
                dbg_hit[dssd_pkg::DSSD_BA1] = 1'b1;
            dssd_pkg::BKPT_ADDR_SECOND,
            dssd_pkg::BKPT_ADDR_SECOND - 24'h1:
                dbg_hit[dssd_pkg::DSSD_BA2] = 1'b1;
            dssd_pkg::BKPT_MASK,
            dssd_pkg::BKPT_MASK - 24'h1:
                dbg_hit[dssd_pkg::DSSD_BMK] = 1'b1;
            dssd_pkg::BKPT_COUNTER:     dbg_hit[dssd_pkg::DSSD_BCN] = 1'b1;
            dssd_pkg::EXT_SIGNAL_CTRL:  dbg_hit[dssd_pkg::DBG_EXT_IDX] = 1'b1;
            default:                    dbg_hit = '0;
        endcase
    end
endmodule : dssd_dbg_dec

// File: verif/dssd_decoder_monitor.sv
// checker: address map and refusal assertions on the decoder top ports
`timescale 1ns/100ps
module dssd_decoder_monitor #(
    parameter int unsigned NSLOT = 27
) (
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             core_req,
    input wire logic             core_wr,
    input wire logic [23:0]      core_addr,
    input wire logic [1:0]       core_size,
    input wire logic [NSLOT-1:0] periph_sel,
    input wire logic             dual_timer_sel,
    input wire logic             gain_amp_first_sel,
    input wire logic             gain_amp_second_sel,
    input wire logic             flash_iface_sel,
    input wire logic [16:0]      dbg_sel,
    input wire logic             sel_wr,
    input wire logic             rd_zero,
    input wire logic             access_err
);
    // =====================================================
    // helpers
    logic word_acc;
    assign word_acc = core_req && core_size == dssd_pkg::DSSD_SZ_WORD;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // =====================================================
    // assertions: one cycle from taken request to select
    timer_slot_a: assert property (
        word_acc && core_addr inside {[24'h00f000:24'h00f01f]}
        |=> dual_timer_sel && periph_sel[0]) else $error("timer slot miss");
    pwm_slot_a: assert property (
        word_acc && core_addr inside {[24'h00f020:24'h00f03f]}
        |=> periph_sel[1] && !dual_timer_sel) else $error("pwm slot miss");
    amp_first_a: assert property (
        word_acc && core_addr inside {[24'h00f0a0:24'h00f0bf]}
        |=> gain_amp_first_sel && periph_sel[5]) else $error("amp0 miss");
    amp_second_a: assert property (
        word_acc && core_addr inside {[24'h00f0c0:24'h00f0df]}
        |=> gain_amp_second_sel && periph_sel[6]) else $error("amp1 miss");
    flash_base_a: assert property (
        word_acc && core_addr inside {[24'h00f400:24'h00f41f]}
        |=> flash_iface_sel && periph_sel[26]) else $error("flash miss");
    size_err_a: assert property (
        core_req && core_size != dssd_pkg::DSSD_SZ_WORD
        && core_addr inside {[24'h00f000:24'h00ffff]}
        |=> access_err && periph_sel == '0) else $error("size not refused");
    dbg_top_a: assert property (
        word_acc && core_addr == 24'hffffff
        |=> dbg_sel == 17'h00001) else $error("upper xfer miss");
    ext_ctrl_a: assert property (
        word_acc && core_addr == 24'hffff8a
        |=> dbg_sel == 17'h10000) else $error("ext ctrl miss");
    dbg_rsvd_a: assert property (
        word_acc && !core_wr && core_addr inside {[24'hffff00:24'hffff89]}
        |=> dbg_sel == '0 && rd_zero) else $error("reserved selected");
    wr_qual_a: assert property (
        word_acc && core_wr && core_addr inside {[24'h00f0c0:24'h00f0df]}
        |=> sel_wr && gain_amp_second_sel) else $error("write qual miss");
    // =====================================================
    // covers
    err_seen_c: cover property (access_err);
    flash_seen_c: cover property (flash_iface_sel);
    dbg_ext_c: cover property (dbg_sel[16]);
endmodule : dssd_decoder_monitor

bind dssd_decoder dssd_decoder_monitor #(.NSLOT(NSLOT)) u_monitor (
    .clk(clk), .sys_rst(sys_rst), .core_req(core_req),
    .core_wr(core_wr), .core_addr(core_addr), .core_size(core_size),
    .periph_sel(periph_sel), .dual_timer_sel(dual_timer_sel),
    .gain_amp_first_sel(gain_amp_first_sel),
    .gain_amp_second_sel(gain_amp_second_sel),
    .flash_iface_sel(flash_iface_sel), .dbg_sel(dbg_sel),
    .sel_wr(sel_wr), .rd_zero(rd_zero), .access_err(access_err));

// File: verif/dssd_tp_model.sv
// partner: test port master, one word request held until answered
`timescale 1ns/100ps
module dssd_tp_model (
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic         go,
    input wire logic         go_wr,
    input wire logic [23:0]  go_addr,
    input wire logic         tp_ack,
    input wire logic         tp_denied,
    input wire logic [16:0]  dbg_sel,
    output logic             tp_req,
    output logic             tp_wr,
    output logic [23:0]      tp_addr,
    output logic             done,
    output logic             saw_den,
    output logic [16:0]      saw_sel
);
    // =====================================================
    // request held steady until an answer; word access only
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (sys_rst) begin
            tp_req <= 1'b0;
            tp_wr <= 1'b0;
            tp_addr <= 24'h5a5a5a;
        end else if (go && !tp_req) begin
            tp_req <= 1'b1;
            tp_wr <= go_wr;
            tp_addr <= go_addr;
        end else if (tp_req && (tp_ack || tp_denied)) begin
            // released lines flip so a stale value never passes
            tp_req <= 1'b0;
            tp_wr <= ~tp_wr;
            tp_addr <= ~tp_addr;
            done <= 1'b1;
            saw_den <= tp_denied;
            saw_sel <= dbg_sel;
        end
    end
endmodule : dssd_tp_model

// File: verif/dssd_decoder_tb.sv
// testbench: core and test port accesses against the data space map
`timescale 1ns/100ps
module dssd_decoder_tb;
    logic clk = 1'b0, sys_rst = 1'b1, core_req = 1'b0, core_wr = 1'b0;
    logic [23:0] core_addr = 24'h0, go_addr = 24'h0, tp_addr;
    logic [1:0]  core_size = 2'h1;
    logic flash_secure = 1'b1, go = 1'b0, tp_req, tp_wr, done, saw_den;
    logic [26:0] periph_sel;
    logic [16:0] dbg_sel, saw_sel;
    logic t0, t2, a0, a1, fl, sel_wr, rd_zero, access_err, tp_denied, tp_ack;
    int miscompares = 0, n_tests = 0;
    always #5 clk = ~clk;
    dssd_decoder #(.NSLOT(27)) dut (.clk(clk), .sys_rst(sys_rst),
        .core_req(core_req), .core_wr(core_wr), .core_addr(core_addr),
        .core_size(core_size), .tp_req(tp_req), .tp_wr(tp_wr),
        .tp_addr(tp_addr), .flash_secure(flash_secure),
        .periph_sel(periph_sel), .dual_timer_sel(t0),
        .irq_arbiter_sel(t2), .gain_amp_first_sel(a0),
        .gain_amp_second_sel(a1), .flash_iface_sel(fl), .dbg_sel(dbg_sel),
        .sel_wr(sel_wr), .rd_zero(rd_zero), .access_err(access_err),
        .tp_denied(tp_denied), .tp_ack(tp_ack));
    dssd_tp_model u_tp (.clk(clk), .sys_rst(sys_rst), .go(go),
        .go_wr(1'b0), .go_addr(go_addr), .tp_ack(tp_ack),
        .tp_denied(tp_denied), .dbg_sel(dbg_sel), .tp_req(tp_req),
        .tp_wr(tp_wr), .tp_addr(tp_addr), .done(done), .saw_den(saw_den),
        .saw_sel(saw_sel));
    // =====================================================
    // shared tasks
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    // one core access, judged at the cycle its answer stands
    task automatic acc(input logic [23:0] a, input logic [1:0] sz,
                       input logic w);
        @(posedge clk);
        core_addr <= a;
        core_size <= sz;
        core_wr <= w;
        core_req <= 1'b1;
        @(posedge clk);
        core_req <= 1'b0;
        #1;
    endtask : acc
    function automatic logic [26:0] pexp(input logic [23:0] a);
        if (a >= 24'h00f000 && a < 24'h00f340)
            return 27'h1 << ((a - 24'h00f000) >> 5);
        if (a >= 24'h00f400 && a < 24'h00f420)
            return 27'h4000000;
        return 27'h0;
    endfunction : pexp
    // =====================================================
    // scenarios
    task automatic t_slots;
        logic [23:0] ad [15] = '{24'h00f000, 24'h00f01f, 24'h00f020,
            24'h00f03f, 24'h00f040, 24'h00f0a0, 24'h00f0bf, 24'h00f0c0,
            24'h00f0df, 24'h00f320, 24'h00f33f, 24'h00f400, 24'h00f41f,
            24'h000100, 24'hfffeff};
        logic [26:0] e;
        foreach (ad[i]) begin
            e = pexp(ad[i]);
            acc(ad[i], 2'h1, 1'b0);
            chk(periph_sel === e, "slot select");
            chk({fl, a1, a0, t2, t0} === {e[26], e[6], e[5], e[2], e[0]},
                "named select");
            chk(access_err === 1'b0 && dbg_sel === 17'h0, "stray flag");
        end
    endtask : t_slots
    task automatic t_size;
        acc(24'h00f0a0, 2'h0, 1'b0);
        chk(access_err === 1'b1 && periph_sel === 27'h0, "byte");
        chk(rd_zero === 1'b1 && a0 === 1'b0, "byte read");
        acc(24'h00f0a0, 2'h2, 1'b1);
        chk(access_err === 1'b1 && a0 === 1'b0, "long");
        acc(24'h000100, 2'h0, 1'b0);
        chk(access_err === 1'b0, "byte outside region");
    endtask : t_size
    task automatic t_dbg;
        logic [7:0] lo [29] = '{8'hff, 8'hfe, 8'hfd, 8'hfc, 8'hfb, 8'ha1,
            8'ha0, 8'h9f, 8'h9e, 8'h9d, 8'h9c, 8'h9b, 8'h9a, 8'h99, 8'h98,
            8'h97, 8'h96, 8'h95, 8'h94, 8'h93, 8'h92, 8'h91, 8'h90, 8'h8f,
            8'h8e, 8'h8d, 8'h8a, 8'h89, 8'h00};
        logic [4:0] ix [29] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1f, 5'h1f,
            5'h04, 5'h05, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0a,
            5'h0b, 5'h0b, 5'h0c, 5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0e, 5'h1f,
            5'h0f, 5'h1f, 5'h10, 5'h1f, 5'h1f};
        foreach (lo[i]) begin
            acc({16'hffff, lo[i]}, 2'h1, 1'b0);
            chk(dbg_sel === (ix[i] == 5'h1f ? 17'h0 : 17'h1 << ix[i]),
                "debug select");
            chk(rd_zero === (ix[i] == 5'h1f), "reserved read");
        end
        acc(24'hffff8f, 2'h1, 1'b1);
        chk(dbg_sel === 17'h0 && rd_zero === 1'b0, "reserved write");
    endtask : t_dbg
    task automatic t_wr;
        acc(24'h00f0c0, 2'h1, 1'b1);
        chk(a1 === 1'b1 && sel_wr === 1'b1, "write select");
        acc(24'h00f0df, 2'h1, 1'b0);
        chk(a1 === 1'b1 && sel_wr === 1'b0, "read select");
    endtask : t_wr
    task automatic t_tp(input logic sec);
        int n;
        @(posedge clk);
        flash_secure <= sec;
        go_addr <= 24'hffff9d;
        repeat (4) @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk);
        if (n == 40) begin
            miscompares++;
            $display("wrong value at %0t: test port timeout", $time);
        end else begin
            chk(saw_den === sec, "test port refusal");
            chk(saw_sel === (sec ? 17'h0 : 17'h00040), "tp select");
        end
    endtask : t_tp
    task automatic summarize;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // =====================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_slots();
        t_size();
        t_dbg();
        t_wr();
        t_tp(1'b0);
        t_tp(1'b1);
        summarize();
    end
endmodule : dssd_decoder_tb
